// ---- include/tss_pkg.sv ----
// What this block does
// - limit register 0 is the iteration count of the counter-0 loop jump
// - limit register 1 is the iteration count of the counter-1 loop jump
// - limit register 0 otherwise is the terminal value of counter 0
// - limit register 1 otherwise is the terminal value of counter 1
// - limits are read-only while steps execute and clear to zero at reset
// - wait-high and wait-low steps pick one of sixteen inputs by 4-bit option
// - interrupt step raises one of eight interrupts with options 0 to 7
// - trigger step pulses one of thirty-two outputs by 5-bit option
// - reserved commands and options act as a no-op and execution continues
package tss_pkg;
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_status = 8'h04;
	localparam logic [7:0] addr_c0_limit = 8'h08;
	localparam logic [7:0] addr_c1_limit = 8'h0c;
	localparam logic [7:0] addr_irq_stat = 8'h10;
	localparam logic [7:0] addr_irq_mask = 8'h14;
	localparam logic [7:0] addr_step_base = 8'h40;
	localparam logic [15:0] limit_reset = 16'h0000;
	localparam int ctrl_run_bit = 0;
	localparam int step_count = 16;
	localparam int pc_width = 4;
	// step word: [7:4] command, [3:0] option; trigger uses [4:0] with cmd 100x
	localparam logic [3:0] cmd_nop = 4'h0;
	localparam logic [3:0] cmd_wait_high = 4'h1;
	localparam logic [3:0] cmd_wait_low = 4'h2;
	localparam logic [3:0] cmd_irq = 4'h3;
	localparam logic [3:0] cmd_jump_c0 = 4'h4;
	localparam logic [3:0] cmd_jump_c1 = 4'h5;
	localparam logic [3:0] cmd_stop = 4'h6;
	localparam logic [2:0] cmd_trig_hi = 3'h4; // cmd[3:1]=100: trigger step
	localparam logic [3:0] irq_last_opt = 4'h7;

	typedef enum logic [2:0] {
		tss_idle = 3'b001,
		tss_exec = 3'b010,
		tss_wait = 3'b100
	} tss_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} tss_wreq_type;
endpackage : tss_pkg

// ---- verilog/tss_sequencer.sv ----
`timescale 1ns/10ps
module tss_sequencer #(
	parameter int n_inputs = 16,
	parameter int n_irqs = 8,
	parameter int n_trigs = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [n_inputs-1:0] trigger_input_n,
	output logic [n_trigs-1:0] trigger_output_n,
	output logic [n_irqs-1:0] seq_irq,
	output logic irq
);
	typedef struct packed {
		tss_pkg::tss_state_type st;
		logic [3:0] pc;
		logic [15:0] c0_limit;
		logic [15:0] c1_limit;
		logic [15:0] cnt0;
		logic [15:0] cnt1;
		logic run;
		logic [7:0] irq_stat;
		logic [7:0] irq_mask;
		logic aw_got;
		logic w_got;
		tss_pkg::tss_wreq_type wr;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] trig;
		logic [7:0] sirq;
		logic [15:0][7:0] prog;
	} tss_regs_type;

	tss_regs_type q, d;
	logic [n_inputs-1:0] in_meta_q, in_sync_q;
	logic [7:0] step;
	logic [3:0] cmd, opt;
	logic wr_fire, wr_ok, rd_fire, cond;

	// two-flop sync of inputs arriving from other peripherals
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_meta_q <= '0;
			in_sync_q <= '0;
		end else begin
			in_meta_q <= trigger_input_n;
			in_sync_q <= in_meta_q;
		end
	end

	assign step = q.prog[q.pc];
	assign cmd = step[7:4];
	assign opt = step[3:0];
	assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
	assign rd_fire = s_axi_arvalid && !q.rvalid;
	assign cond = (cmd == tss_pkg::cmd_wait_high) ?
		in_sync_q[opt] : !in_sync_q[opt];

	// next state: bus slave, step engine, interrupt flags
	always_comb begin
		d = q;
		wr_ok = 1'b1;
		d.trig = '0;
		d.sirq = '0;
		if (s_axi_awvalid && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.wr.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got) begin
			d.w_got = 1'b1;
			d.wr.data = s_axi_wdata;
			d.wr.strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		// step execution, one step per cycle unless waiting
		unique case (q.st)
			tss_pkg::tss_idle: begin
				if (q.run) begin
					d.st = tss_pkg::tss_exec;
					d.pc = '0;
					// fresh loop counts each run, so a limit lowered
					// while idle is never overshot
					d.cnt0 = '0;
					d.cnt1 = '0;
				end
			end
			tss_pkg::tss_exec, tss_pkg::tss_wait: begin
				d.pc = q.pc + 4'h1;
				d.st = tss_pkg::tss_exec;
				if (!q.run) begin
					d.st = tss_pkg::tss_idle;
				end else if (cmd[3:1] == tss_pkg::cmd_trig_hi) begin
					d.trig[{cmd[0], opt}] = 1'b1;
				end else begin
					unique case (cmd)
						tss_pkg::cmd_wait_high, tss_pkg::cmd_wait_low: begin
							if (!cond) begin
								d.pc = q.pc;
								d.st = tss_pkg::tss_wait;
							end
						end
						tss_pkg::cmd_irq: begin
							// codes 8..15 fall through as no-op
							if (opt <= tss_pkg::irq_last_opt) begin
								d.sirq[opt[2:0]] = 1'b1;
								d.irq_stat[opt[2:0]] = 1'b1;
							end
						end
						tss_pkg::cmd_jump_c0: begin
							if (q.cnt0 != q.c0_limit) begin
								d.cnt0 = q.cnt0 + 16'h0001;
								d.pc = step[3:0];
							end else begin
								d.cnt0 = '0;
							end
						end
						tss_pkg::cmd_jump_c1: begin
							if (q.cnt1 != q.c1_limit) begin
								d.cnt1 = q.cnt1 + 16'h0001;
								d.pc = step[3:0];
							end else begin
								d.cnt1 = '0;
							end
						end
						tss_pkg::cmd_stop: begin
							d.run = 1'b0;
							d.st = tss_pkg::tss_idle;
						end
						default: ; // reserved commands: no-op
					endcase
				end
			end
			default: d.st = tss_pkg::tss_idle;
		endcase
		// register writes after engine so software clears lose to new sets
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			unique case (q.wr.addr & 8'hfc)
				tss_pkg::addr_ctrl: begin
					if (q.wr.strb[0])
						d.run = q.wr.data[tss_pkg::ctrl_run_bit];
				end
				tss_pkg::addr_c0_limit: begin
					if (q.st == tss_pkg::tss_idle) begin
						if (q.wr.strb[0]) d.c0_limit[7:0] = q.wr.data[7:0];
						if (q.wr.strb[1]) d.c0_limit[15:8] = q.wr.data[15:8];
					end else begin
						wr_ok = 1'b0;
					end
				end
				tss_pkg::addr_c1_limit: begin
					if (q.st == tss_pkg::tss_idle) begin
						if (q.wr.strb[0]) d.c1_limit[7:0] = q.wr.data[7:0];
						if (q.wr.strb[1]) d.c1_limit[15:8] = q.wr.data[15:8];
					end else begin
						wr_ok = 1'b0;
					end
				end
				tss_pkg::addr_irq_stat: begin
					// write one clears, but a same-cycle set survives
					if (q.wr.strb[0])
						d.irq_stat = q.irq_stat & ~q.wr.data[7:0] | d.sirq;
				end
				tss_pkg::addr_irq_mask: begin
					if (q.wr.strb[0])
						d.irq_mask = q.wr.data[7:0];
				end
				tss_pkg::addr_status: wr_ok = 1'b0;
				default: begin
					if (q.wr.addr[7:6] == 2'b01 && q.st == tss_pkg::tss_idle) begin
						if (q.wr.strb[0])
							d.prog[q.wr.addr[5:2]] = q.wr.data[7:0];
					end else begin
						wr_ok = 1'b0;
					end
				end
			endcase
			d.bresp = wr_ok ? 2'b00 : 2'b10;
		end
		// reads
		if (rd_fire) begin
			d.rvalid = 1'b1;
			d.rresp = 2'b00;
			d.rdata = '0;
			unique case (s_axi_araddr & 8'hfc)
				tss_pkg::addr_ctrl: d.rdata[0] = q.run;
				tss_pkg::addr_status: d.rdata = {24'h0, 1'b0, q.st, q.pc};
				tss_pkg::addr_c0_limit: d.rdata[15:0] = q.c0_limit;
				tss_pkg::addr_c1_limit: d.rdata[15:0] = q.c1_limit;
				tss_pkg::addr_irq_stat: d.rdata[7:0] = q.irq_stat;
				tss_pkg::addr_irq_mask: d.rdata[7:0] = q.irq_mask;
				default: begin
					if (s_axi_araddr[7:6] == 2'b01)
						d.rdata[7:0] = q.prog[s_axi_araddr[5:2]];
					else
						d.rresp = 2'b10;
				end
			endcase
		end
	end

	// single state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= tss_pkg::tss_idle;
			q.c0_limit <= tss_pkg::limit_reset;
			q.c1_limit <= tss_pkg::limit_reset;
		end else begin
			q <= d;
		end
	end

	// pulses and bus answers come straight from the state register
	assign seq_irq = q.sirq[n_irqs-1:0];
	assign trigger_output_n = q.trig[n_trigs-1:0];
	assign irq = |(q.irq_stat & q.irq_mask);
	assign s_axi_awready = !q.aw_got;
	assign s_axi_wready = !q.w_got;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	// limit locking while the engine runs
	a_limit_locked: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle && $past(q.st) != tss_pkg::tss_idle
		|-> $stable(q.c0_limit) && $stable(q.c1_limit))
		else $error("limit changed while running");
	a_limit_refused: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && q.st != tss_pkg::tss_idle
		&& (q.wr.addr & 8'hfc) == tss_pkg::addr_c0_limit
		|=> q.bresp == 2'b10 && $stable(q.c0_limit))
		else $error("locked limit write not refused");
	// reserved codes must leave no trace
	a_irq_reserved: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$past(q.st) == tss_pkg::tss_exec && $past(cmd) == tss_pkg::cmd_irq
		&& $past(opt) > 4'h7 && $past(q.run) |-> q.sirq == 8'h00)
		else $error("reserved irq option had effect");
	a_reserved_cmd: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st == tss_pkg::tss_exec && q.run
		&& (cmd == 4'h7 || cmd >= 4'ha)
		|=> q.sirq == 8'h00 && q.trig == 32'h0
		&& q.pc == $past(q.pc) + 4'h1)
		else $error("reserved command had effect");
	// option decoding of interrupt, trigger and wait steps
	a_irq_select: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st == tss_pkg::tss_exec && q.run && cmd == tss_pkg::cmd_irq
		&& opt < 4'h8 |=> q.sirq == (8'h01 << $past(opt[2:0])))
		else $error("wrong interrupt raised");
	a_trig_select: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st == tss_pkg::tss_exec && q.run && cmd[3:1] == 3'h4
		|=> q.trig == (32'h1 << $past({cmd[0], opt})))
		else $error("wrong trigger pulsed");
	a_trig_pulse: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.trig != 32'h0 |-> $past(q.st) != tss_pkg::tss_idle)
		else $error("trigger without step");
	a_wait_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle && q.run && (cmd == tss_pkg::cmd_wait_high
		|| cmd == tss_pkg::cmd_wait_low) && !cond |=> $stable(q.pc))
		else $error("wait step advanced early");
	// loop jumps against the limits
	a_loop_fall: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle && q.run && cmd == tss_pkg::cmd_jump_c0
		&& q.cnt0 == q.c0_limit |=> q.cnt0 == 16'h0)
		else $error("loop counter 0 not cleared");
	a_loop_take: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle && q.run && cmd == tss_pkg::cmd_jump_c1
		&& q.cnt1 != q.c1_limit |=> q.cnt1 == $past(q.cnt1) + 16'h1)
		else $error("loop counter 1 not counted");
	a_loop_back: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle && q.run && cmd == tss_pkg::cmd_jump_c0
		&& q.cnt0 != q.c0_limit |=> q.pc == $past(opt))
		else $error("loop 0 did not branch");
	a_loop_exit: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle && q.run && cmd == tss_pkg::cmd_jump_c1
		&& q.cnt1 == q.c1_limit |=> q.pc == $past(q.pc) + 4'h1)
		else $error("loop 1 did not fall through");
	a_cnt0_bound: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle |-> q.cnt0 <= q.c0_limit)
		else $error("counter 0 passed its limit");
	a_cnt1_bound: assert property (
		@(posedge aclk) disable iff (!aresetn)
		q.st != tss_pkg::tss_idle |-> q.cnt1 <= q.c1_limit)
		else $error("counter 1 passed its limit");
	// each bus answer is given once and then withdrawn
	a_bvalid_once: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rvalid_once: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	// main scenarios
	c_irq_step: cover property (@(posedge aclk) q.sirq != 8'h0);
	c_trig_step: cover property (@(posedge aclk) q.trig != 32'h0);
	c_locked_write: cover property (@(posedge aclk)
		q.bvalid && q.bresp == 2'b10);
	c_wait_step: cover property (@(posedge aclk) q.st == tss_pkg::tss_wait);
	c_loop_done: cover property (@(posedge aclk)
		q.st != tss_pkg::tss_idle && cmd == tss_pkg::cmd_jump_c1
		&& q.cnt1 == q.c1_limit && q.cnt1 != 16'h0);
endmodule : tss_sequencer

// ---- test/tss_peer_model.sv ----
`timescale 1ns/10ps
// far-side peripherals: hold input levels, tally output pulses
module tss_peer_model (
	input wire logic aclk,
	input wire logic [15:0] level,
	output logic [15:0] trigger_input_n,
	input wire logic [31:0] trigger_output_n,
	input wire logic [7:0] seq_irq
);
	int trig_cnt[32];
	int irq_cnt[8];
	// levels come from the bench; the block synchronises them
	assign trigger_input_n = level;
	// sampled on the falling edge, clear of the block's own updates
	always @(negedge aclk) begin
		for (int b = 0; b < 32; b++) trig_cnt[b] += int'(trigger_output_n[b]);
		for (int b = 0; b < 8; b++) irq_cnt[b] += int'(seq_irq[b]);
	end
endmodule : tss_peer_model

// ---- test/test_trigger_step_sequencer_options.sv ----
`timescale 1ns/10ps
module test_trigger_step_sequencer_options;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [15:0] level = 16'hffff;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, trig, rd;
	logic [7:0] sirq;
	logic [15:0] tin;
	int mismatches = 0, compares = 0, cyc = 0, seed = 32'hda43;
	int exp_trig[32], exp_irq[8];
	int o, o2, o3, k, i, j, l0, l1;
	logic [7:0] prog[$];
	always #50 aclk = ~aclk;
	tss_sequencer dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.trigger_input_n(tin), .trigger_output_n(trig), .seq_irq(sirq),
		.irq(irq));
	tss_peer_model peer (.aclk(aclk), .level(level), .trigger_input_n(tin),
		.trigger_output_n(trig), .seq_irq(sirq));
	task chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk
	task tally_and_finish;
		if (mismatches == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	// handshakes judged at the rising edge, released right after it
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic tb;
		tb = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				tb = 1'b1;
				rs = bresp;
				bready <= 1'b0;
			end
		end
		// one idle edge keeps the next call off this release
		@(posedge aclk);
	endtask : axw
	task axr(input logic [7:0] a);
		logic tr;
		tr = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				tr = 1'b1;
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
			end
		end
		@(posedge aclk);
	endtask : axr
	task irq_is(input logic v);
		@(negedge aclk);
		chk(32'(irq), 32'(v));
		@(posedge aclk);
	endtask : irq_is
	// hang guard, well above the few hundred cycles needed
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(tss_pkg::addr_c0_limit);
		chk(rd, 32'h0);
		axr(tss_pkg::addr_c1_limit);
		chk(rd, 32'h0);
		l0 = 1 + ($random(seed) & 3);
		l1 = 1 + ($random(seed) & 3);
		o = $random(seed) & 31;
		o2 = $random(seed) & 31;
		o3 = $random(seed) & 31;
		k = $random(seed) & 7;
		i = $random(seed) & 15;
		j = (i + 1) & 15;
		// reserved irq option and reserved command go in on purpose
		prog = '{8'(128 + o), 8'(48 + k), 8'(56 + ($random(seed) & 7)),
			8'ha0, 8'(128 + o2), 8'h44, 8'(32 + j), 8'(16 + i),
			8'(128 + o3), 8'h58, 8'h60};
		exp_trig[o]++;
		exp_trig[o2] += l0 + 1;
		exp_trig[o3] += l1 + 1;
		exp_irq[k] = 1;
		axw(tss_pkg::addr_c0_limit, 32'(l0));
		axw(tss_pkg::addr_c1_limit, 32'(l1));
		axr(tss_pkg::addr_c1_limit);
		chk(rd, 32'(l1));
		for (int s = 0; s < prog.size(); s++)
			axw(8'(tss_pkg::addr_step_base + 4 * s), 32'(prog[s]));
		level <= ~(16'h1 << i);
		axw(tss_pkg::addr_ctrl, 32'h1);
		repeat (30) @(posedge aclk);
		chk(peer.trig_cnt[o3], exp_trig[o3] - l1 - 1);
		axw(tss_pkg::addr_c0_limit, 32'hffff);
		chk(32'(rs), 32'h2);
		axr(tss_pkg::addr_c0_limit);
		chk(rd, 32'(l0));
		level[j] <= 1'b0;
		repeat (20) @(posedge aclk);
		chk(peer.trig_cnt[o3], exp_trig[o3] - l1 - 1);
		level[i] <= 1'b1;
		repeat (40) @(posedge aclk);
		for (int b = 0; b < 32; b++)
			chk(peer.trig_cnt[b], exp_trig[b]);
		for (int b = 0; b < 8; b++)
			chk(peer.irq_cnt[b], exp_irq[b]);
		axw(tss_pkg::addr_ctrl, 32'h0);
		axr(tss_pkg::addr_irq_stat);
		chk(rd, 32'h1 << k);
		irq_is(1'b0);
		axw(tss_pkg::addr_irq_mask, 32'h1 << k);
		irq_is(1'b1);
		axw(tss_pkg::addr_irq_stat, 32'h1 << k);
		irq_is(1'b0);
		axr(8'h30);
		chk({rd[29:0], rs}, 32'h2); // unmapped reads give error and zero
		tally_and_finish;
	end
endmodule : test_trigger_step_sequencer_options
